// ===== ubra_pkg.sv
// Purpose: Shared constants and types for the dual-channel banked UART register decoder.
// Assumes: An 8-bit register bus with a 3-bit offset and one chip select per channel.
// Notes: All offsets, bank codes, bit positions and reset values live here once.
package ubra_pkg;

  // Register offsets on the 3-bit address bus.
  localparam logic [2:0] OFS_DIV_LOW = 3'h0;
  localparam logic [2:0] OFS_DIV_HIGH = 3'h1;
  localparam logic [2:0] OFS_ENH = 3'h2;
  localparam logic [2:0] OFS_LINE = 3'h3;
  localparam logic [2:0] OFS_MODEM = 3'h4;
  localparam logic [2:0] OFS_RESUME1 = 3'h4;
  localparam logic [2:0] OFS_RESUME2 = 3'h5;
  localparam logic [2:0] OFS_HALT1 = 3'h6;
  localparam logic [2:0] OFS_HALT2 = 3'h7;
  localparam logic [2:0] OFS_THRESH = 3'h6;
  localparam logic [2:0] OFS_TRIGGER = 3'h7;
  localparam logic [2:0] OFS_READY = 3'h7;

  // Line control values that select a bank.
  localparam logic [7:0] LINE_DIV_BANK = 8'h80;
  localparam logic [7:0] LINE_EXT_BANK = 8'hBF;

  // Bit positions of the gating and mode bits.
  localparam int ENH_ENABLE_BIT = 4;
  localparam int LINE_DIV_BIT = 7;
  localparam int MODEM_GATE_BIT = 6;
  localparam int MODEM_LOOP_BIT = 4;
  localparam int MODEM_PRESC_BIT = 7;
  localparam int MODEM_PROT_LSB = 5;
  localparam int READY_TX_LSB = 0;
  localparam int READY_RX_LSB = 4;

  // Reset value of every stored register.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Prescaler: last count of the divide-by-four sequence.
  localparam logic [1:0] PRESC_LAST = 2'h3;
  localparam logic [1:0] PRESC_RESET = 2'h0;

  // Decoded target of one access.
  localparam logic [3:0] SEL_BASE = 4'h0;
  localparam logic [3:0] SEL_LINE = 4'h1;
  localparam logic [3:0] SEL_DIV_LOW = 4'h2;
  localparam logic [3:0] SEL_DIV_HIGH = 4'h3;
  localparam logic [3:0] SEL_ENH = 4'h4;
  localparam logic [3:0] SEL_RESUME1 = 4'h5;
  localparam logic [3:0] SEL_RESUME2 = 4'h6;
  localparam logic [3:0] SEL_HALT1 = 4'h7;
  localparam logic [3:0] SEL_HALT2 = 4'h8;
  localparam logic [3:0] SEL_MODEM = 4'h9;
  localparam logic [3:0] SEL_THRESH = 4'hA;
  localparam logic [3:0] SEL_TRIGGER = 4'hB;
  localparam logic [3:0] SEL_READY = 4'hC;

  // Bus access state, one-hot.
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_WRITE = 3'b010,
    BUS_READ = 3'b100
  } ubra_bus_t;

  // Complete state of the decoder.
  typedef struct packed {
    ubra_bus_t bus;
    logic [1:0][7:0] line;
    logic [1:0][7:0] enh;
    logic [1:0][7:0] modem;
    logic [1:0][7:0] div_low;
    logic [1:0][7:0] div_high;
    logic [1:0][7:0] resume1;
    logic [1:0][7:0] resume2;
    logic [1:0][7:0] halt1;
    logic [1:0][7:0] halt2;
    logic [1:0][7:0] thresh;
    logic [1:0][7:0] trigger;
    logic [1:0][1:0] presc_cnt;
    logic [1:0] baud_tick;
    logic [7:0] rdata;
    logic rdata_oe;
    logic [1:0] base_wr;
    logic [1:0] base_rd;
    logic [2:0] base_addr;
    logic [7:0] base_wdata;
  } ubra_state_t;

endpackage

// ===== ubra_regbank.sv
// Purpose: Banked register decoder for both channels of a dual UART, with the baud prescaler.
// Assumes: Bus inputs are synchronous to core_clk; strobes last at least two clock cycles.
// Notes: Offsets that fall to no extended register are forwarded to the base register file.
//
// Overview of operation
// - Line control bit 7 set maps offsets 0 and 1 to divisor low and high.
// - Line control 0xBF maps offset 2 to the enhanced feature register.
// - In bank 0xBF offset 4 is first resume char, offset 6 first halt char.
// - In bank 0xBF offset 5 is second resume char, offset 7 second halt char.
// - Enhanced enable, base bank and modem bit 6 map offset 6 to threshold.
// - Enhanced enable, base bank and modem bit 6 map offset 7 to trigger levels; reads also need modem bit 4 set.
// - Base bank, modem bit 6 set, bit 4 clear: read of offset 7 returns FIFO ready.
// - Modem bit 7 set divides the clock by four before the baud generator.
// - Modem bit 7 clear passes the clock undivided to the baud generator.
// - In the base bank offset 4 is modem control, read back in full.
// - Writes to modem bits 7 to 5 are ignored unless enhanced enable is set.
// - Threshold and trigger writes need enhanced enable and modem bit 6 both set.
`timescale 1ns/1ps

module ubra_regbank
  import ubra_pkg::*;
(
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cs_a_n,
  input wire logic cs_b_n,
  input wire logic [2:0] addr,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe,
  input wire logic [7:0] base_rdata_a,
  input wire logic [7:0] base_rdata_b,
  output logic [1:0] base_wr_stb,
  output logic [1:0] base_rd_stb,
  output logic [2:0] base_addr,
  output logic [7:0] base_wdata,
  input wire logic [1:0] tx_fifo_ready,
  input wire logic [1:0] rx_fifo_ready,
  output logic [1:0][7:0] line_control,
  output logic [1:0][7:0] enhanced_feature_control,
  output logic [1:0][7:0] modem_control,
  output logic [1:0][15:0] baud_divisor,
  output logic [1:0][7:0] resume_char_first,
  output logic [1:0][7:0] resume_char_second,
  output logic [1:0][7:0] halt_char_first,
  output logic [1:0][7:0] halt_char_second,
  output logic [1:0][7:0] flow_threshold_levels,
  output logic [1:0][7:0] fifo_trigger_levels,
  output logic [1:0] baud_tick
);

  // Every register of both channels lives in one packed state word.
  // The next-state copy is filled in one place, so no field can gain a second driver.
  ubra_state_t state_ff;
  ubra_state_t nxt_state;
  logic [7:0] ready_word;
  logic [1:0] chan_sel;
  logic chan_idx;

  // Decode one access of one channel from its own bank state.
  // Reads and writes share the decode so a register reads back where it was written unless the ready view covers it.
  // Priority runs from the always-visible line control offset down to the gated registers.
  // The ready view sits above the trigger levels, so a read at offset 7 with the view open
  // never returns the trigger byte; writes skip that view because it is read-only.
  function automatic logic [3:0] decode_target(
    input logic [7:0] line,
    input logic [7:0] enh,
    input logic [7:0] modem,
    input logic [2:0] ofs,
    input logic is_read
  );
    logic ext_bank;
    logic div_bank;
    logic gated;
    logic [3:0] sel;
    ext_bank = (line == LINE_EXT_BANK);
    div_bank = line[LINE_DIV_BIT];
    // The gated registers need the divisor bank closed as well, not line control exactly zero.
    gated = enh[ENH_ENABLE_BIT] & modem[MODEM_GATE_BIT] & ~div_bank;
    sel = SEL_BASE;
    if (ofs == OFS_LINE) begin
      sel = SEL_LINE;
    end else if (div_bank && (ofs == OFS_DIV_LOW)) begin
      sel = SEL_DIV_LOW;
    end else if (div_bank && (ofs == OFS_DIV_HIGH)) begin
      sel = SEL_DIV_HIGH;
    end else if (ext_bank) begin
      case (ofs)
        OFS_ENH: sel = SEL_ENH;
        OFS_RESUME1: sel = SEL_RESUME1;
        OFS_HALT1: sel = SEL_HALT1;
        OFS_RESUME2: sel = SEL_RESUME2;
        OFS_HALT2: sel = SEL_HALT2;
        default: sel = SEL_BASE;
      endcase
    end else if (ofs == OFS_MODEM) begin
      sel = SEL_MODEM;
    end else if (is_read && !div_bank && (ofs == OFS_READY) && modem[MODEM_GATE_BIT] &&
                 !modem[MODEM_LOOP_BIT]) begin
      sel = SEL_READY;
    end else if (gated && (ofs == OFS_THRESH)) begin
      sel = SEL_THRESH;
    end else if (gated && (ofs == OFS_TRIGGER)) begin
      sel = SEL_TRIGGER;
    end
    return sel;
  endfunction

  // Ready status of both channels, unused bits held at zero.
  // The status is live, so a read shows the level of the cycle in which its data is loaded.
  // Nothing is latched here; a host that needs a stable copy must read it once and keep it.
  always_comb begin
    ready_word = 8'h00;
    ready_word[READY_TX_LSB +: 2] = tx_fifo_ready;
    ready_word[READY_RX_LSB +: 2] = rx_fifo_ready;
  end

  // Channel A wins if both selects are low, so one access never lands in two channels.
  // A host that drops both selects in mid-read simply ends the access in the sequencer.
  // Each channel decodes from its own line, enhanced and modem bytes only.
  assign chan_sel = {~cs_b_n, ~cs_a_n};
  assign chan_idx = cs_a_n;

  // Next-state logic: bus sequencing, banked writes, read mux and prescalers.
  always_comb begin
    logic [3:0] sel;
    logic [7:0] rd_value;
    logic [7:0] base_value;
    logic any_sel;
    sel = SEL_BASE;
    rd_value = 8'h00;
    base_value = 8'h00;
    any_sel = |chan_sel;
    nxt_state = state_ff;
    nxt_state.base_wr = 2'b00;
    nxt_state.base_rd = 2'b00;

    // Access sequencing: a write is taken once per strobe, a read drives data while held.
    case (state_ff.bus)
      BUS_IDLE: begin
        nxt_state.rdata_oe = 1'b0;
        // Write wins over read when both strobes are low in the same cycle.
        if (any_sel && !wr_n) begin
          sel = decode_target(state_ff.line[chan_idx], state_ff.enh[chan_idx],
                              state_ff.modem[chan_idx], addr, 1'b0);
          nxt_state.bus = BUS_WRITE;
          case (sel)
            SEL_LINE: nxt_state.line[chan_idx] = data_in;
            SEL_DIV_LOW: nxt_state.div_low[chan_idx] = data_in;
            SEL_DIV_HIGH: nxt_state.div_high[chan_idx] = data_in;
            SEL_ENH: nxt_state.enh[chan_idx] = data_in;
            SEL_RESUME1: nxt_state.resume1[chan_idx] = data_in;
            SEL_RESUME2: nxt_state.resume2[chan_idx] = data_in;
            SEL_HALT1: nxt_state.halt1[chan_idx] = data_in;
            SEL_HALT2: nxt_state.halt2[chan_idx] = data_in;
            SEL_MODEM: begin
              // The top three bits keep their value unless enhanced mode opens them.
              if (state_ff.enh[chan_idx][ENH_ENABLE_BIT]) begin
                nxt_state.modem[chan_idx] = data_in;
              end else begin
                nxt_state.modem[chan_idx] = {state_ff.modem[chan_idx][7:MODEM_PROT_LSB],
                                             data_in[MODEM_PROT_LSB-1:0]};
              end
            end
            SEL_THRESH: nxt_state.thresh[chan_idx] = data_in;
            SEL_TRIGGER: nxt_state.trigger[chan_idx] = data_in;
            default: begin
              // Bit 0 is channel A; the pulse goes only to the channel that owns the access.
              nxt_state.base_wr = {chan_idx, ~chan_idx};
              nxt_state.base_addr = addr;
              nxt_state.base_wdata = data_in;
            end
          endcase
        end else if (any_sel && !rd_n) begin
          nxt_state.bus = BUS_READ;
          // One pulse per read so a popping base register advances only once.
          nxt_state.base_rd = {chan_idx, ~chan_idx};
          nxt_state.base_addr = addr;
        end
      end
      BUS_WRITE: begin
        // A held write strobe is not taken again; the host must lift it for a cycle.
        nxt_state.rdata_oe = 1'b0;
        if (wr_n) begin
          nxt_state.bus = BUS_IDLE;
        end
      end
      BUS_READ: begin
        // Dropping either the strobe or the select ends the read and frees the data bus.
        if (rd_n || !any_sel) begin
          nxt_state.bus = BUS_IDLE;
          nxt_state.rdata_oe = 1'b0;
        end else begin
          nxt_state.rdata_oe = 1'b1;
        end
      end
      default: begin
        // An illegal state code falls back to idle with the data bus released.
        nxt_state.bus = BUS_IDLE;
        nxt_state.rdata_oe = 1'b0;
      end
    endcase

    // Read mux, refreshed every cycle of a read so live status is not stale.
    // Extended reads still pulse the base read strobe at read start; the base data is then ignored.
    if ((state_ff.bus == BUS_READ) && !rd_n && any_sel) begin
      sel = decode_target(state_ff.line[chan_idx], state_ff.enh[chan_idx],
                          state_ff.modem[chan_idx], addr, 1'b1);
      base_value = chan_idx ? base_rdata_b : base_rdata_a;
      case (sel)
        SEL_LINE: rd_value = state_ff.line[chan_idx];
        SEL_DIV_LOW: rd_value = state_ff.div_low[chan_idx];
        SEL_DIV_HIGH: rd_value = state_ff.div_high[chan_idx];
        SEL_ENH: rd_value = state_ff.enh[chan_idx];
        SEL_RESUME1: rd_value = state_ff.resume1[chan_idx];
        SEL_RESUME2: rd_value = state_ff.resume2[chan_idx];
        SEL_HALT1: rd_value = state_ff.halt1[chan_idx];
        SEL_HALT2: rd_value = state_ff.halt2[chan_idx];
        SEL_MODEM: rd_value = state_ff.modem[chan_idx];
        SEL_THRESH: rd_value = state_ff.thresh[chan_idx];
        SEL_TRIGGER: rd_value = state_ff.trigger[chan_idx];
        SEL_READY: rd_value = ready_word;
        default: rd_value = base_value;
      endcase
      nxt_state.rdata = rd_value;
    end

    // Prescalers, one per channel: a tick every fourth cycle or every cycle.
    // The counter restarts from zero when divide-by-four is switched off, so the first
    // tick after switching it back on always comes four cycles later.
    for (int ch = 0; ch < 2; ch++) begin
      if (state_ff.modem[ch][MODEM_PRESC_BIT]) begin
        nxt_state.presc_cnt[ch] = state_ff.presc_cnt[ch] + 2'h1;
        nxt_state.baud_tick[ch] = (state_ff.presc_cnt[ch] == PRESC_LAST);
      end else begin
        nxt_state.presc_cnt[ch] = PRESC_RESET;
        nxt_state.baud_tick[ch] = 1'b1;
      end
    end
  end

  // State register with synchronous reset.
  // All stored bytes start at zero, so a host that skips configuration still finds
  // the base bank open and the prescaler off.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff.bus <= BUS_IDLE;
      state_ff.line <= {2{REG_RESET}};
      state_ff.enh <= {2{REG_RESET}};
      state_ff.modem <= {2{REG_RESET}};
      state_ff.div_low <= {2{REG_RESET}};
      state_ff.div_high <= {2{REG_RESET}};
      state_ff.resume1 <= {2{REG_RESET}};
      state_ff.resume2 <= {2{REG_RESET}};
      state_ff.halt1 <= {2{REG_RESET}};
      state_ff.halt2 <= {2{REG_RESET}};
      state_ff.thresh <= {2{REG_RESET}};
      state_ff.trigger <= {2{REG_RESET}};
      state_ff.presc_cnt <= {2{PRESC_RESET}};
      state_ff.baud_tick <= 2'b00;
      state_ff.rdata <= 8'h00;
      state_ff.rdata_oe <= 1'b0;
      state_ff.base_wr <= 2'b00;
      state_ff.base_rd <= 2'b00;
      state_ff.base_addr <= 3'h0;
      state_ff.base_wdata <= 8'h00;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Outputs are direct views of state flip-flops.
  assign data_out = state_ff.rdata;
  assign data_oe = state_ff.rdata_oe;
  assign base_wr_stb = state_ff.base_wr;
  assign base_rd_stb = state_ff.base_rd;
  assign base_addr = state_ff.base_addr;
  assign base_wdata = state_ff.base_wdata;
  assign line_control = state_ff.line;
  assign enhanced_feature_control = state_ff.enh;
  assign modem_control = state_ff.modem;
  assign resume_char_first = state_ff.resume1;
  assign resume_char_second = state_ff.resume2;
  assign halt_char_first = state_ff.halt1;
  assign halt_char_second = state_ff.halt2;
  assign flow_threshold_levels = state_ff.thresh;
  assign fifo_trigger_levels = state_ff.trigger;
  assign baud_tick = state_ff.baud_tick;
  // The divisor halves are written separately, so the word is only settled after both bytes have been written.
  assign baud_divisor[0] = {state_ff.div_high[0], state_ff.div_low[0]};
  assign baud_divisor[1] = {state_ff.div_high[1], state_ff.div_low[1]};

endmodule

// ===== ubra_regbank_checker.sv
// Purpose: Port assertions for the banked register decoder.
// Assumes: Channel A carries the checked traffic; channel B is watched for isolation.
// Notes: Access starts are found from the strobe level one cycle earlier.
`timescale 1ns/1ps
module ubra_regbank_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cs_a_n,
  input wire logic [2:0] addr,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic data_oe,
  input wire logic [1:0] base_wr_stb,
  input wire logic [1:0] base_rd_stb,
  input wire logic [1:0][7:0] line_control,
  input wire logic [1:0][7:0] enhanced_feature_control,
  input wire logic [1:0][7:0] modem_control,
  input wire logic [1:0] baud_tick
);
  logic wr_q;
  logic rd_q;
  // Reset parks the history high, so a strobe held through reset is taken as a new access, as the decoder does.
  always_ff @(posedge core_clk) begin
    wr_q <= sys_rst | wr_n;
    rd_q <= sys_rst | rd_n;
  end
  wire wa = !cs_a_n && !wr_n && wr_q;
  wire wb = cs_a_n && !wr_n && wr_q;
  wire ra = !cs_a_n && !rd_n && rd_q;
  wire [7:0] lca = line_control[0];
  wire [7:0] mca = modem_control[0];
  wire [7:0] efa = enhanced_feature_control[0];
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  property p_line; wa && addr == 3'h3 |=> lca == $past(data_in); endproperty
  a_line: assert property (p_line) else $error("line write lost");
  property p_enh; wa && addr == 3'h2 && lca == 8'hBF |=> efa == $past(data_in); endproperty
  a_enh: assert property (p_enh) else $error("enhanced write lost");
  property p_iso; wb |=> $stable(lca) && $stable(mca); endproperty
  a_iso: assert property (p_iso) else $error("channel B write hit A");
  property p_lock; wa && addr == 3'h4 && lca != 8'hBF && !efa[4] |=> mca[7:5] == $past(mca[7:5]); endproperty
  a_lock: assert property (p_lock) else $error("locked modem bits moved");
  property p_ref; wa && addr == 3'h6 && lca == 8'h00 && !mca[6] |=> base_wr_stb == 2'b01; endproperty
  a_ref: assert property (p_ref) else $error("ungated write not sent to base");
  property p_rds; ra |=> base_rd_stb == 2'b01; endproperty
  a_rds: assert property (p_rds) else $error("base read pulse missing");
  property p_mrd; ra && addr == 3'h4 && lca == 8'h00 ##1 !rd_n |=> data_oe && data_out == mca; endproperty
  a_mrd: assert property (p_mrd) else $error("modem read wrong");
  property p_div4; mca[7] [*6] |-> $countones({baud_tick[0], $past(baud_tick[0]), $past(baud_tick[0], 2),
    $past(baud_tick[0], 3)}) == 1; endproperty
  a_div4: assert property (p_div4) else $error("tick not one in four");
  property p_div1; !mca[7] [*2] |-> baud_tick[0]; endproperty
  a_div1: assert property (p_div1) else $error("tick not steady");
  c_ref: cover property (wa && addr == 3'h6);
  c_rdy: cover property (ra && addr == 3'h7);
  c_div4: cover property (mca[7] && baud_tick[0]);
endmodule

bind ubra_regbank ubra_regbank_checker chk_u (.core_clk, .sys_rst, .cs_a_n, .addr, .wr_n, .rd_n, .data_in,
  .data_out, .data_oe, .base_wr_stb, .base_rd_stb, .line_control, .enhanced_feature_control, .modem_control,
  .baud_tick);

// ===== ubra_host.sv
// Purpose: Host processor model on the 8-bit register bus of both channels.
// Assumes: Signals change 1 ns after a rising edge and hold through the edge that takes them.
// Notes: Released write data shows the inverse of the last byte, so stale data is never trusted.
`timescale 1ns/1ps
module ubra_host (
  input wire logic core_clk,
  input wire logic [7:0] data_out,
  output logic cs_a_n,
  output logic cs_b_n,
  output logic [2:0] addr,
  output logic wr_n,
  output logic rd_n,
  output logic [7:0] data_in
);
  // Bus idle at time zero.
  initial {cs_a_n, cs_b_n, wr_n, rd_n, addr, data_in} = {4'hF, 3'h0, 8'h00};
  // One write, taken at the first edge; the strobe then stays high for a cycle.
  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk) #1 {cs_a_n, cs_b_n, addr, data_in, wr_n} = {ch, !ch, a, d, 1'b0};
    @(posedge core_clk) #1 {cs_a_n, cs_b_n, wr_n, data_in} = {2'h3, 1'b1, ~d};
  endtask
  // One read; data is taken at the third edge, after the device loaded it.
  task automatic rd(input logic ch, input logic [2:0] a, output logic [7:0] q);
    @(posedge core_clk) #1 {cs_a_n, cs_b_n, addr, rd_n} = {ch, !ch, a, 1'b0};
    repeat (3) @(posedge core_clk);
    q = data_out;
    #1 {cs_a_n, cs_b_n, rd_n} = 3'h7;
  endtask
  // Save line control, open a bank, write and read back one register, restore.
  task automatic bank(input logic ch, input logic [7:0] b, input logic [2:0] a, input logic [7:0] d,
    output logic [7:0] q);
    logic [7:0] t;
    rd(ch, 3'h3, t);
    wr(ch, 3'h3, b);
    wr(ch, a, d);
    rd(ch, a, q);
    wr(ch, 3'h3, t);
  endtask
  // Enhanced mode on, base bank, a modem change, then restored in reverse order; with pre set the modem change is kept.
  task automatic gated(input logic ch, input logic [2:0] a, input logic [7:0] d, input logic pre);
    logic [7:0] t1, t2, t3;
    rd(ch, 3'h3, t1);
    wr(ch, 3'h3, 8'hBF);
    rd(ch, 3'h2, t2);
    wr(ch, 3'h2, t2 | 8'h10);
    wr(ch, 3'h3, 8'h00);
    rd(ch, 3'h4, t3);
    if (pre) begin
      wr(ch, 3'h4, d[7] ? t3 | 8'h80 : t3 & 8'h7F);
    end else begin
      wr(ch, 3'h4, t3 | 8'h40);
      wr(ch, a, d);
      wr(ch, 3'h4, t3);
    end
    wr(ch, 3'h3, 8'hBF);
    wr(ch, 3'h2, t2);
    wr(ch, 3'h3, t1);
  endtask
  // Loop-back cleared and ready view opened only for the one read.
  task automatic rd_ready(input logic ch, output logic [7:0] q);
    logic [7:0] t;
    rd(ch, 3'h4, t);
    wr(ch, 3'h4, t & 8'hEF | 8'h40);
    rd(ch, 3'h7, q);
    wr(ch, 3'h4, t);
  endtask
endmodule

// ===== uart_banked_register_access_bench.sv
// Purpose: Self-checking bench for the dual-channel banked register decoder.
// Assumes: The host model owns the bus; FIFO status and base read data stay constant.
// Notes: Table rows cover the bank registers; gating, prescaler and reset follow by hand.
`timescale 1ns/1ps
module uart_banked_register_access_bench;
  logic core_clk, sys_rst, cs_a_n, cs_b_n, wr_n, rd_n, data_oe;
  logic [2:0] addr, base_addr;
  logic [7:0] data_in, data_out, base_rdata_a, base_rdata_b, base_wdata, q;
  logic [1:0] base_wr_stb, base_rd_stb, tx_fifo_ready, rx_fifo_ready, baud_tick;
  logic [1:0][7:0] line_control, enhanced_feature_control, modem_control, resume_char_first;
  logic [1:0][7:0] resume_char_second, halt_char_first, halt_char_second, flow_threshold_levels, fifo_trigger_levels;
  logic [1:0][15:0] baud_divisor;
  int errors, cmp_count;
  // Row: channel bit, offset, then the byte written and expected back.
  logic [11:0] rows [14] = '{12'h012, 12'h134, 12'h246, 12'h478, 12'h59A, 12'h6BC, 12'h7DE, 12'h8F1,
    12'h923, 12'hA45, 12'hC67, 12'hD89, 12'hEAB, 12'hFCD};

  ubra_regbank dut_u (.core_clk, .sys_rst, .cs_a_n, .cs_b_n, .addr, .wr_n, .rd_n, .data_in, .data_out, .data_oe,
    .base_rdata_a, .base_rdata_b, .base_wr_stb, .base_rd_stb, .base_addr, .base_wdata, .tx_fifo_ready,
    .rx_fifo_ready, .line_control, .enhanced_feature_control, .modem_control, .baud_divisor, .resume_char_first,
    .resume_char_second, .halt_char_first, .halt_char_second, .flow_threshold_levels, .fifo_trigger_levels,
    .baud_tick);
  ubra_host host_u (.core_clk, .data_out, .cs_a_n, .cs_b_n, .addr, .wr_n, .rd_n, .data_in);

  // Case equality, so an unknown byte never passes.
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done;
    $display("compares %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Free-running 10 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // The tests need well under 200 us; a hung handshake ends the run here.
  initial begin
    #500us;
    errors++;
    test_done();
  end
  // Table first, then the gated, refused, status, prescaler and reset cases.
  initial begin
    {sys_rst, base_rdata_a, base_rdata_b, tx_fifo_ready, rx_fifo_ready} = {1'b1, 8'hC3, 8'h3C, 2'b10, 2'b01};
    repeat (2) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    foreach (rows[i]) begin
      host_u.bank(rows[i][11], rows[i][10:9] == 2'h0 ? 8'h80 : 8'hBF, rows[i][10:8], rows[i][7:0], q);
      chk8("bank reg", rows[i][7:0], q);
    end
    chk8("isolation", 8'h78, resume_char_first[0]);
    chk8("divisor a high", 8'h34, baud_divisor[0][15:8]);
    chk8("divisor b low", 8'hF1, baud_divisor[1][7:0]);
    host_u.wr(1'b0, 3'h4, 8'hFF);
    chk8("modem locked", 8'h1F, modem_control[0]);
    host_u.bank(1'b0, 8'hBF, 3'h2, 8'h10, q);
    host_u.wr(1'b0, 3'h4, 8'h65);
    host_u.rd(1'b0, 3'h4, q);
    chk8("modem open", 8'h65, q);
    host_u.gated(1'b0, 3'h6, 8'h3C, 1'b0);
    host_u.gated(1'b0, 3'h7, 8'h5A, 1'b0);
    chk8("threshold", 8'h3C, flow_threshold_levels[0]);
    chk8("trigger", 8'h5A, fifo_trigger_levels[0]);
    host_u.wr(1'b0, 3'h4, 8'h25);
    host_u.wr(1'b0, 3'h6, 8'h99);
    chk8("base wdata", 8'h99, base_wdata);
    chk8("base addr", 8'h06, {5'h00, base_addr});
    chk8("refused threshold", 8'h3C, flow_threshold_levels[0]);
    host_u.rd_ready(1'b0, q);
    chk8("fifo ready", 8'h12, q);
    host_u.rd(1'b0, 3'h5, q);
    chk8("base read", 8'hC3, q);
    host_u.gated(1'b0, 3'h0, 8'h80, 1'b1);
    q = 8'h00;
    repeat (8) @(negedge core_clk) q += {7'h00, baud_tick[0]};
    chk8("div4 ticks", 8'h02, q);
    host_u.gated(1'b0, 3'h0, 8'h00, 1'b1);
    q = 8'h00;
    repeat (8) @(negedge core_clk) q += {7'h00, baud_tick[0]};
    chk8("div1 ticks", 8'h08, q);
    @(posedge core_clk) #1 sys_rst = 1'b1;
    repeat (2) @(posedge core_clk);
    #1 sys_rst = 1'b0;
    host_u.rd(1'b0, 3'h4, q);
    chk8("modem after reset", 8'h00, q);
    test_done();
  end
endmodule
